// ===== common/irs_defs.svh
// constants of the internal ram, stack and register bank block
// assumes inclusion by its bare name from irs_top and tb_top
`ifndef IRS_DEFS_SVH
`define IRS_DEFS_SVH
// ram map
`define IRS_SYS_SEG 8'h00
`define IRS_RAM_BASE 16'hFA00
`define IRS_RAM_LAST 16'hFDFF
`define IRS_BIT_BASE 16'hFD00
// stack areas
`define IRS_STK_TOP 16'hFBFE
`define IRS_STK_TOP_MAX 16'hFDFE
`define IRS_STK_BOT_256 16'hFA00
`define IRS_STK_BOT_128 16'hFB00
`define IRS_STK_BOT_64 16'hFB80
`define IRS_STK_BOT_32 16'hFBC0
`define IRS_STKSZ_MAX 3'h7
`define IRS_STKSZ_POS 0
// register offsets
`define IRS_OFS_SYSCFG 8'h00
`define IRS_OFS_SP 8'h04
`define IRS_OFS_STKLO 8'h08
`define IRS_OFS_STKHI 8'h0C
`define IRS_OFS_CP 8'h10
`define IRS_OFS_CPSAVE 8'h14
`define IRS_OFS_STATUS 8'h18
`define IRS_OFS_PAGE0 8'h1C
`define IRS_OFS_LAST 8'h28
// reset values
`define IRS_RST_STKSZ 3'h0
`define IRS_RST_SP 16'hFC00
`define IRS_RST_STKLO 16'hFA00
`define IRS_RST_STKHI 16'hFC00
`define IRS_RST_CP 16'hFC00
`endif

// ===== common/irs_pkg.sv
// types of the internal ram, stack and register bank block
// assumes irs_defs.svh on the include path
`default_nettype none
package irs_pkg;
	typedef enum logic [2:0] {irs_op_load = 3'h0, irs_op_store = 3'h1,
		irs_op_fetch = 3'h2, irs_op_push = 3'h3, irs_op_pop = 3'h4,
		irs_op_swap = 3'h5} irs_op_t;
	typedef enum logic [1:0] {irs_am_long = 2'h0, irs_am_paged = 2'h1,
		irs_am_reg = 2'h2} irs_amode_t;
	typedef enum logic [1:0] {irs_sz_byte = 2'h0, irs_sz_word = 2'h1,
		irs_sz_bit = 2'h2} irs_size_t;
	typedef enum logic [2:0] {irs_st_idle = 3'h1, irs_st_mod = 3'h2,
		irs_st_rsp = 3'h4} irs_state_t;
endpackage
`default_nettype wire

// ===== common/irs_ram_if.sv
// carrier between the block logic and its ram array
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface irs_ram_if;
	logic en;
	logic [1:0] we;
	logic [8:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport user (output en, output we, output addr, output wdata,
		input rdata);
	modport mem (input en, input we, input addr, input wdata,
		output rdata);
endinterface
`default_nettype wire

// ===== rtl/irs_ram.sv
// 512 x 16 on-chip ram with byte lanes and registered read
// assumes the user side holds en, we, addr and wdata for one cycle
`timescale 1ns/1ns
`default_nettype none
module irs_ram
(
	// clock, reset, freeze
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ce,
	// access port
	irs_ram_if.mem bus
);
	logic [15:0] mem [0:511];

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always_ff @(posedge ref_clk)
		if (ce && bus.en)
		begin
			if (bus.we[0])
				mem[bus.addr][7:0] <= bus.wdata[7:0];
			if (bus.we[1])
				mem[bus.addr][15:8] <= bus.wdata[15:8];
		end

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			bus.rdata <= 16'h0000;
		else if (ce && bus.en)
			bus.rdata <= mem[bus.addr];

	chk_write_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(ce && bus.en && bus.we == 2'h3) ##1 !bus.en ##1
		(ce && bus.en && bus.we == 2'h0
		&& bus.addr == $past(bus.addr, 2))
		|=> bus.rdata == $past(bus.wdata, 3))
		else $error("ram word not read back");
endmodule
`default_nettype wire

// ===== rtl/irs_top.sv
// internal ram, system stack and register bank logic
// assumes an axi4-lite master and the core on ref_clk
`timescale 1ns/1ns
`default_nettype none
`include "irs_defs.svh"
module irs_top
(
	// clock, reset, freeze
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ce,
	// axi4-lite register slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// core request
	input wire logic core_valid,
	output logic core_ready,
	input wire irs_pkg::irs_op_t core_op,
	input wire irs_pkg::irs_amode_t core_amode,
	input wire irs_pkg::irs_size_t core_size,
	input wire logic [23:0] core_addr,
	input wire logic [3:0] core_reg,
	input wire logic [3:0] core_bit,
	input wire logic [15:0] core_wdata,
	// core answer
	output logic core_done,
	output logic core_fault,
	output logic [15:0] core_rdata,
	// stack events
	output logic stack_ovf,
	output logic stack_unf
);
	import irs_pkg::*;

	logic [2:0] stksz;
	logic [15:0] sp;
	logic [15:0] stk_lo;
	logic [15:0] stk_hi;
	logic [15:0] cp;
	logic [15:0] cp_saved;
	logic [9:0] ppage [0:3];
	irs_state_t state;
	irs_size_t q_size;
	logic q_fault;
	logic q_hi;
	logic q_wbit;
	logic [3:0] q_bit;
	logic [8:0] q_idx;
	logic take;
	logic take_w;
	logic take_r;
	logic mem_op;
	logic circ;
	logic hit;
	logic bit_ok;
	logic fault;
	logic wr;
	logic rmw;
	logic ovf_set;
	logic unf_set;
	logic [15:0] reg_ofs;
	logic [15:0] next_sp;
	logic [23:0] phys;
	logic [15:0] mask;
	logic [31:0] next_rdata;

	irs_ram_if ram_bus();

	irs_ram u_ram
	(
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.ce(ce),
		.bus(ram_bus)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [8:0] ram_idx(input logic [15:0] a);
		logic [15:0] d;
		d = a - `IRS_RAM_BASE;
		return d[9:1];
	endfunction

	function automatic logic ram_hit(input logic [23:0] a);
		return a[23:16] == `IRS_SYS_SEG && a[15:0] >= `IRS_RAM_BASE
			&& a[15:0] <= `IRS_RAM_LAST;
	endfunction

	function automatic logic [15:0] stk_bottom(input logic [2:0] sz);
		case (sz)
		3'h1: return `IRS_STK_BOT_128;
		3'h2: return `IRS_STK_BOT_64;
		3'h3: return `IRS_STK_BOT_32;
		default: return `IRS_STK_BOT_256;
		endcase
	endfunction

	function automatic logic [15:0] stk_top(input logic [2:0] sz);
		return (sz == `IRS_STKSZ_MAX) ? `IRS_STK_TOP_MAX : `IRS_STK_TOP;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] strb);
		return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic ofs_ok(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= `IRS_OFS_LAST;
	endfunction

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	assign core_ready = ce && (state == irs_st_idle);
	assign take = ce && core_valid && core_ready;
	assign mem_op = (core_op != irs_op_swap);
	assign circ = (stksz != `IRS_STKSZ_MAX);

	always_comb
	begin
		case (core_op)
		irs_op_push:
			if (circ && sp == stk_bottom(stksz))
				next_sp = stk_top(stksz);
			else
				next_sp = sp - 16'h0002;
		irs_op_pop:
			if (circ && sp == stk_top(stksz))
				next_sp = stk_bottom(stksz);
			else
				next_sp = sp + 16'h0002;
		default:
			next_sp = sp;
		endcase
	end

	always_comb
	begin
		if (core_size == irs_sz_byte)
			reg_ofs = {12'h000, core_reg};
		else
			reg_ofs = {11'h000, core_reg, 1'b0};
		case (core_amode)
		irs_am_paged:
			phys = {ppage[core_addr[15:14]], core_addr[13:0]};
		irs_am_reg:
			phys = {`IRS_SYS_SEG, cp + reg_ofs};
		default:
			phys = core_addr;
		endcase
		if (core_op == irs_op_push)
			phys = {`IRS_SYS_SEG, next_sp};
		else if (core_op == irs_op_pop)
			phys = {`IRS_SYS_SEG, sp};
		if (core_size != irs_sz_byte || core_op == irs_op_fetch
			|| core_op == irs_op_push || core_op == irs_op_pop)
			phys[0] = 1'b0;
	end

	assign hit = ram_hit(phys);
	assign bit_ok = core_size != irs_sz_bit || core_op != irs_op_load
		&& core_op != irs_op_store || core_amode == irs_am_reg
		|| phys[15:0] >= `IRS_BIT_BASE;
	assign fault = mem_op && !(hit && bit_ok);
	assign wr = (core_op == irs_op_store || core_op == irs_op_push);
	assign rmw = (core_op == irs_op_store && core_size == irs_sz_bit);
	assign mask = 16'h0001 << q_bit;

	// ----------------------------------------
	// ram drive
	// ----------------------------------------
	always_comb
	begin
		ram_bus.en = take && mem_op && !fault;
		ram_bus.addr = ram_idx(phys[15:0]);
		ram_bus.we = 2'h0;
		ram_bus.wdata = core_wdata;
		if (state == irs_st_mod)
		begin
			ram_bus.en = 1'b1;
			ram_bus.addr = q_idx;
			ram_bus.we = {q_bit[3], ~q_bit[3]};
			ram_bus.wdata = q_wbit ? (ram_bus.rdata | mask)
				: (ram_bus.rdata & ~mask);
		end
		else if (wr && !rmw)
		begin
			if (core_size == irs_sz_byte && core_op == irs_op_store)
			begin
				ram_bus.we = {phys[0], ~phys[0]};
				ram_bus.wdata = {core_wdata[7:0], core_wdata[7:0]};
			end
			else
				ram_bus.we = 2'h3;
		end
	end

	// ----------------------------------------
	// access sequence
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			state <= irs_st_idle;
		else if (ce)
			case (state)
			irs_st_idle:
				if (core_valid)
					state <= (rmw && !fault) ? irs_st_mod : irs_st_rsp;
			irs_st_mod:
				state <= irs_st_rsp;
			irs_st_rsp:
				state <= irs_st_idle;
			default:
				state <= irs_st_idle;
			endcase

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			q_size <= irs_sz_word;
			q_fault <= 1'b0;
			q_hi <= 1'b0;
			q_wbit <= 1'b0;
			q_bit <= 4'h0;
			q_idx <= 9'h000;
		end
		else if (take)
		begin
			q_size <= core_size;
			q_fault <= fault;
			q_hi <= phys[0];
			q_wbit <= core_wdata[0];
			q_bit <= core_bit;
			q_idx <= ram_idx(phys[15:0]);
		end

	assign core_done = (state == irs_st_rsp);
	assign core_fault = core_done && q_fault;

	always_comb
	begin
		case (q_size)
		irs_sz_byte:
			core_rdata = {8'h00, q_hi ? ram_bus.rdata[15:8]
				: ram_bus.rdata[7:0]};
		irs_sz_bit:
			core_rdata = {15'h0000, ram_bus.rdata[q_bit]};
		default:
			core_rdata = ram_bus.rdata;
		endcase
	end

	// ----------------------------------------
	// stack registers
	// ----------------------------------------
	assign take_w = ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = take_w;
	assign s_axi_wready = take_w;

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			stksz <= `IRS_RST_STKSZ;
			stk_lo <= `IRS_RST_STKLO;
			stk_hi <= `IRS_RST_STKHI;
		end
		else if (ce && take_w)
			case (s_axi_awaddr)
			`IRS_OFS_SYSCFG:
				if (s_axi_wstrb[0])
					stksz <= s_axi_wdata[`IRS_STKSZ_POS +: 3];
			`IRS_OFS_STKLO:
				stk_lo <= merge16(stk_lo, s_axi_wdata, s_axi_wstrb);
			`IRS_OFS_STKHI:
				stk_hi <= merge16(stk_hi, s_axi_wdata, s_axi_wstrb);
			default:
				stksz <= stksz;
			endcase

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			sp <= `IRS_RST_SP;
		else if (take && !fault
			&& (core_op == irs_op_push || core_op == irs_op_pop))
			sp <= next_sp;
		else if (ce && take_w && s_axi_awaddr == `IRS_OFS_SP)
			sp <= merge16(sp, s_axi_wdata, s_axi_wstrb);

	// ----------------------------------------
	// stack events
	// ----------------------------------------
	assign ovf_set = take && core_op == irs_op_push && next_sp < stk_lo;
	assign unf_set = take && core_op == irs_op_pop && next_sp > stk_hi;

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			stack_ovf <= 1'b0;
			stack_unf <= 1'b0;
		end
		else if (ce)
		begin
			if (ovf_set)
				stack_ovf <= 1'b1;
			else if (take_w && s_axi_awaddr == `IRS_OFS_STATUS
				&& s_axi_wstrb[0] && s_axi_wdata[0])
				stack_ovf <= 1'b0;
			if (unf_set)
				stack_unf <= 1'b1;
			else if (take_w && s_axi_awaddr == `IRS_OFS_STATUS
				&& s_axi_wstrb[0] && s_axi_wdata[1])
				stack_unf <= 1'b0;
		end

	// ----------------------------------------
	// bank base and page pointers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			cp <= `IRS_RST_CP;
			cp_saved <= `IRS_RST_CP;
		end
		else if (take && core_op == irs_op_swap)
		begin
			cp_saved <= cp;
			cp <= core_wdata;
		end
		else if (ce && take_w && s_axi_awaddr == `IRS_OFS_CP)
			cp <= merge16(cp, s_axi_wdata, s_axi_wstrb);

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			for (int i = 0; i < 4; i++)
				ppage[i] <= i[9:0];
		else if (ce && take_w)
			for (int i = 0; i < 4; i++)
				if (s_axi_awaddr == `IRS_OFS_PAGE0 + 8'(4 * i))
					ppage[i] <= 10'(merge16({6'h00, ppage[i]},
						s_axi_wdata, s_axi_wstrb));

	// ----------------------------------------
	// axi responses
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else if (ce)
		begin
			if (take_w)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= ofs_ok(s_axi_awaddr) ? 2'h0 : 2'h3;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end

	assign take_r = ce && s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = take_r;

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (s_axi_araddr)
		`IRS_OFS_SYSCFG: next_rdata[`IRS_STKSZ_POS +: 3] = stksz;
		`IRS_OFS_SP: next_rdata[15:0] = sp;
		`IRS_OFS_STKLO: next_rdata[15:0] = stk_lo;
		`IRS_OFS_STKHI: next_rdata[15:0] = stk_hi;
		`IRS_OFS_CP: next_rdata[15:0] = cp;
		`IRS_OFS_CPSAVE: next_rdata[15:0] = cp_saved;
		`IRS_OFS_STATUS: next_rdata[1:0] = {stack_unf, stack_ovf};
		default:
			for (int i = 0; i < 4; i++)
				if (s_axi_araddr == `IRS_OFS_PAGE0 + 8'(4 * i))
					next_rdata[9:0] = ppage[i];
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0000_0000;
		end
		else if (ce)
		begin
			if (take_r)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= ofs_ok(s_axi_araddr) ? 2'h0 : 2'h3;
				s_axi_rdata <= next_rdata;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_push_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && core_op == irs_op_push && !fault && sp != stk_bottom(stksz)
		|=> sp == $past(sp) - 16'h0002)
		else $error("push did not lower pointer by two");

	chk_big_nowrap: assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && core_op == irs_op_push && stksz == 3'h7 && !fault
		|=> sp == $past(sp) - 16'h0002)
		else $error("largest stack wrapped");

	chk_odd_byte: assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && core_op == irs_op_store && core_size == irs_sz_byte
		&& !fault && phys[0]
		|-> ram_bus.we == 2'h2)
		else $error("odd byte not in high lane");

	chk_bit_region: assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && core_op == irs_op_load && core_size == irs_sz_bit
		&& core_amode == irs_am_long && core_addr[15:0] < 16'hFD00
		|=> core_done && core_fault)
		else $error("bit access below bit area accepted");

	chk_page_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && core_amode == irs_am_paged && core_op == irs_op_load
		&& ppage[core_addr[15:14]] != 10'h003
		|=> core_fault)
		else $error("paged access off page three reached ram");

	chk_ctx_save: assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && core_op == irs_op_swap
		|=> cp_saved == $past(cp) && cp == $past(core_wdata) ##1 !core_done)
		else $error("context swap lost old base");

	chk_reg_addr: assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && core_amode == irs_am_reg && core_size == irs_sz_word
		&& core_op == irs_op_load && !fault
		|-> ram_bus.addr == ram_idx(cp + {11'h000, core_reg, 1'b0}))
		else $error("word register address wrong");

	chk_ovf_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ovf_set |=> stack_ovf)
		else $error("overflow flag not held");

	chk_bit_rmw: assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && rmw && !fault |=> state == irs_st_mod ##1 core_done)
		else $error("bit write sequence broken");
endmodule
`default_nettype wire

// ===== tb/irs_core_model.sv
// core-side partner: issues operand requests and collects answers
// assumes one request at a time, called from the bench on ref_clk
`timescale 1ns/1ns
`default_nettype none
module irs_core_model
(
	// clock
	input wire logic ref_clk,
	// request
	output logic core_valid,
	input wire logic core_ready,
	output var irs_pkg::irs_op_t core_op,
	output var irs_pkg::irs_amode_t core_amode,
	output var irs_pkg::irs_size_t core_size,
	output logic [23:0] core_addr,
	output logic [3:0] core_reg,
	output logic [3:0] core_bit,
	output logic [15:0] core_wdata,
	// answer
	input wire logic core_done,
	input wire logic core_fault,
	input wire logic [15:0] core_rdata
);
	import irs_pkg::*;
	initial
	begin
		core_valid = 1'b0;
		core_op = irs_op_load;
		core_amode = irs_am_long;
		core_size = irs_sz_word;
		core_addr = 24'h000000;
		core_reg = 4'h0;
		core_bit = 4'h0;
		core_wdata = 16'h0000;
	end
	// one request held until taken; answer read in its own cycle
	task automatic req(input irs_op_t o, input irs_amode_t m,
		input irs_size_t s, input logic [23:0] a, input logic [7:0] rb,
		input logic [15:0] d, output logic [15:0] q, output logic f);
		@(posedge ref_clk);
		core_valid <= 1'b1;
		core_op <= o;
		core_amode <= m;
		core_size <= s;
		core_addr <= a;
		core_reg <= rb[7:4];
		core_bit <= rb[3:0];
		core_wdata <= d;
		@(negedge ref_clk);
		while (core_ready !== 1'b1)
			@(negedge ref_clk);
		@(posedge ref_clk);
		// released address and write data show garbage, not the last value
		core_valid <= 1'b0;
		core_addr <= ~a;
		core_wdata <= ~d;
		@(negedge ref_clk);
		while (core_done !== 1'b1)
			@(negedge ref_clk);
		q = core_rdata;
		f = core_fault;
	endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the ram, stack and register bank block
// assumes irs_core_model as core and an axi4-lite master in here
`timescale 1ns/1ns
`default_nettype none
`include "irs_defs.svh"
module tb_top;
	import irs_pkg::*;
	logic ref_clk, rst_b, ce;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic core_valid, core_ready, core_done, core_fault;
	irs_op_t core_op;
	irs_amode_t core_amode;
	irs_size_t core_size;
	logic [23:0] core_addr;
	logic [3:0] core_reg, core_bit;
	logic [15:0] core_wdata, core_rdata, w, q;
	logic stack_ovf, stack_unf, f;
	logic [31:0] rs, rd;
	logic [1:0] rr;
	logic [15:0] bank [16];
	logic [23:0] fa [6];
	int miscompares, check_count, cyc, i, n;
	irs_top u_dut
	(
		.ref_clk, .rst_b, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_valid,
		.core_ready, .core_op, .core_amode, .core_size, .core_addr,
		.core_reg, .core_bit, .core_wdata, .core_done, .core_fault,
		.core_rdata, .stack_ovf, .stack_unf
	);
	irs_core_model u_core
	(
		.ref_clk, .core_valid, .core_ready, .core_op, .core_amode,
		.core_size, .core_addr, .core_reg, .core_bit, .core_wdata,
		.core_done, .core_fault, .core_rdata
	);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[15:0];
	endfunction
	function automatic logic [15:0] rst_val(input int k);
		case (k)
			1, 3, 4, 5: return 16'hFC00;
			2: return 16'hFA00;
			8: return 16'h0001;
			9: return 16'h0002;
			10: return 16'h0003;
			default: return 16'h0000;
		endcase
	endfunction
	function automatic logic [15:0] stk_bot(input int sz);
		case (sz)
			1: return 16'hFB00;
			2: return 16'hFB80;
			3: return 16'hFBC0;
			default: return 16'hFA00;
		endcase
	endfunction
	task automatic chk16(input string nm, input logic [15:0] e, g);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk2(input string nm, input logic [1:0] e, g);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		@(negedge ref_clk);
		while (s_axi_awready !== 1'b1)
			@(negedge ref_clk);
		@(posedge ref_clk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		@(negedge ref_clk);
		while (s_axi_bvalid !== 1'b1)
			@(negedge ref_clk);
		rr = s_axi_bresp;
		@(posedge ref_clk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		@(negedge ref_clk);
		while (s_axi_arready !== 1'b1)
			@(negedge ref_clk);
		@(posedge ref_clk);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		@(negedge ref_clk);
		while (s_axi_rvalid !== 1'b1)
			@(negedge ref_clk);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		@(posedge ref_clk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic cq(input irs_op_t o, input irs_amode_t m,
		input irs_size_t s, input logic [23:0] a, input logic [15:0] d,
		input logic [7:0] rb);
		// register mode gets a random address that must not matter
		u_core.req(o, m, s, (m == irs_am_reg) ? {8'h00, rnd()} : a,
			rb, d, q, f);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ------------------------------------------------------------
	// clock, timeout and sequence
	// ------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			final_report();
		end
	end
	initial
	begin
		{rs, miscompares, check_count, cyc} = {32'h00000057, 96'h0};
		{ce, rst_b, s_axi_awaddr, s_axi_araddr} = {2'h2, 16'h0000};
		{s_axi_wdata, s_axi_wstrb} = {32'h00000000, 4'h3};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		fa = '{24'h01FA10, 24'h00F9FE, 24'h00FE00, 24'h00FA10,
			24'h003A10, 24'h00FA10};
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		for (i = 0; i < 12; i++)
		begin
			axr(8'(i * 4));
			chk16("reset_val", rst_val(i), rd[15:0]);
			chk2("rresp", (i == 11) ? 2'h3 : 2'h0, rr);
		end
		$display("test reset_map done");
		w = rnd();
		cq(irs_op_store, irs_am_long, irs_sz_word, 24'h00FA10, w, 8'h00);
		cq(irs_op_load, irs_am_long, irs_sz_byte, 24'h00FA10, w, 8'h00);
		chk16("byte_even", {8'h00, w[7:0]}, q);
		cq(irs_op_load, irs_am_long, irs_sz_byte, 24'h00FA11, w, 8'h00);
		chk16("byte_odd", {8'h00, w[15:8]}, q);
		cq(irs_op_load, irs_am_long, irs_sz_word, 24'h00FA11, w, 8'h00);
		chk16("word_odd", w, q);
		// fetch stays well inside ram, clear of its last word
		cq(irs_op_fetch, irs_am_long, irs_sz_word, 24'h00FA11, w, 8'h00);
		chk16("fetch_odd", w, q);
		cq(irs_op_store, irs_am_long, irs_sz_word, 24'h00FD02, w, 8'h00);
		for (i = 0; i < 16; i = i + 15)
		begin
			cq(irs_op_load, irs_am_long, irs_sz_bit, 24'h00FD02, w, 8'(i));
			chk16("bit_load", {15'h0, w[i]}, q);
		end
		cq(irs_op_store, irs_am_long, irs_sz_bit, 24'h00FD02, {15'h0, ~w[9]},
			8'h09);
		cq(irs_op_load, irs_am_long, irs_sz_word, 24'h00FD02, w, 8'h00);
		chk16("bit_store", w ^ 16'h0200, q);
		$display("test storage_order done");
		for (i = 0; i < 6; i++)
		begin
			cq(irs_op_load, (i > 3) ? irs_am_paged : irs_am_long,
				(i == 3) ? irs_sz_bit : irs_sz_word, fa[i], w, 8'h00);
			chk2("fault", {1'b0, i != 5}, {1'b0, f});
		end
		chk16("paged_p3", w, q);
		axw(8'h1C, 16'h0003);
		cq(irs_op_load, irs_am_paged, irs_sz_word, 24'h003A10, w, 8'h00);
		chk16("paged_ptr", w, q);
		$display("test decode done");
		// reserved size codes are never written
		for (i = 0; i < 4; i++)
		begin
			w = rnd();
			axw(8'h00, 16'(i));
			axw(8'h04, stk_bot(i));
			cq(irs_op_push, irs_am_long, irs_sz_word, 24'h0, w, 8'h00);
			axr(8'h04);
			chk16("sp_wrap", `IRS_STK_TOP, rd[15:0]);
			cq(irs_op_push, irs_am_long, irs_sz_word, 24'h0, ~w, 8'h00);
			cq(irs_op_load, irs_am_long, irs_sz_word, 24'h00FBFC, w, 8'h00);
			chk16("stack_down", ~w, q);
			cq(irs_op_pop, irs_am_long, irs_sz_word, 24'h0, w, 8'h00);
			chk16("pop1", ~w, q);
			cq(irs_op_pop, irs_am_long, irs_sz_word, 24'h0, w, 8'h00);
			chk16("pop2", w, q);
			axr(8'h04);
			chk16("sp_unwrap", stk_bot(i), rd[15:0]);
		end
		axw(8'h00, 16'h0007);
		axw(8'h04, 16'hFA02);
		cq(irs_op_push, irs_am_long, irs_sz_word, 24'h0, w, 8'h00);
		chk2("no_ovf", 2'h0, {1'b0, stack_ovf});
		cq(irs_op_push, irs_am_long, irs_sz_word, 24'h0, w, 8'h00);
		chk2("ovf_flag", 2'h1, {1'b0, stack_ovf});
		axr(8'h04);
		chk16("sp_nowrap", 16'hFA00, rd[15:0]);
		axr(8'h18);
		chk16("status_ovf", 16'h0001, rd[15:0]);
		axw(8'h18, 16'h0003);
		axw(8'h04, 16'hFC00);
		cq(irs_op_pop, irs_am_long, irs_sz_word, 24'h0, w, 8'h00);
		chk2("unf_flag", 2'h1, {stack_ovf, stack_unf});
		axr(8'h04);
		chk16("sp_pop", 16'hFC02, rd[15:0]);
		$display("test stack done");
		axw(8'h10, 16'hFA40);
		for (i = 0; i < 16; i++)
		begin
			bank[i] = rnd();
			cq(irs_op_store, irs_am_reg, irs_sz_word, 24'h0, bank[i],
				{4'(i), 4'h0});
			cq(irs_op_load, irs_am_long, irs_sz_word, 24'h00FA40 + 24'(2 * i),
				w, 8'h00);
			chk16("reg_word", bank[i], q);
		end
		for (i = 0; i < 8; i++)
		begin
			w = rnd();
			n = int'(w[11:9]);
			cq(irs_op_store, irs_am_reg, irs_sz_byte, 24'h0, w, {w[11:8], 4'h0});
			if (w[8])
				bank[n][15:8] = w[7:0];
			else
				bank[n][7:0] = w[7:0];
			cq(irs_op_load, irs_am_long, irs_sz_word, 24'h00FA40 + 24'(2 * n),
				w, 8'h00);
			chk16("byte_reg", bank[n], q);
			cq(irs_op_store, irs_am_reg, irs_sz_bit, 24'h0, {15'h0, w[4]},
				{w[15:12], w[3:0]});
			bank[w[15:12]][w[3:0]] = w[4];
			cq(irs_op_load, irs_am_reg, irs_sz_bit, 24'h0, w, {w[15:12], w[3:0]});
			chk16("reg_bit", {15'h0, w[4]}, q);
		end
		w = rnd();
		cq(irs_op_store, irs_am_long, irs_sz_word, 24'h00FB00, w, 8'h00);
		cq(irs_op_swap, irs_am_reg, irs_sz_word, 24'h0, 16'hFB00, 8'h00);
		axr(8'h10);
		chk16("new_base", 16'hFB00, rd[15:0]);
		axw(8'h14, 16'h1234);
		axr(8'h14);
		chk16("saved_base", 16'hFA40, rd[15:0]);
		cq(irs_op_load, irs_am_reg, irs_sz_word, 24'h0, w, 8'h00);
		chk16("swapped_r0", w, q);
		axw(8'h40, 16'h0000);
		chk2("unmapped_wr", 2'h3, rr);
		$display("test bank done");
		final_report();
	end
endmodule
`default_nettype wire
